// [hdl/conv_out.sv]
// Operation
// [R1] Drive clock and data pins; chip select ignored (code drives the clock pin in internal mode only)
// [R2] Latch clock source when power-on ends
// [R3] Pin undriven at reset selects internal clocking
// [R4] Pin held low selects external mode
// [R5] Converting: clock and data held high
// [R6] Conversion done: both pins pulled low
// [R7] Output runs first to nineteenth rising edge
// [R8] Data changes on falling edges; clock output
// [R9] Receiver samples on rising edges one-nineteen
// [R10] After edge nineteen data high, clock high
// [R11] Select low: internal 69900 Hz sampling pace
// [R12] Convert and shift repeat with no host
// [R13] Select clocked: conversions paced by that clock
`timescale 1ns/100ps
`default_nettype none
module conv_out
    import conv_out_pkg::*;
#(
    parameter int unsigned POR_LEN = POR_CYCLES
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Result words from the modulator core
    input wire logic [RESULT_W-1:0] result_i,
    input wire logic result_valid_i,
    output logic result_ready_o,
    // Pin levels seen from outside
    input wire logic sck_pin_i,
    input wire logic oscillator_select_pin_i,
    // Serial clock pin, input during power-on, driven after it in internal mode only
    output logic sck_o,
    output logic sck_oe_o,
    output logic sdo_o,
    output logic sdo_oe_o,
    // Mode latched at power-on end: 1 internal clocking
    output logic int_mode_o,
    // Conversion pacing tick for the modulator
    output logic sample_tick_o
);
    typedef enum logic [1:0] {S_POR, S_CONV, S_DONE, S_SHIFT} state_t;
    state_t state_r, state_nxt;

    // Three-stage synchronisers for the pins
    logic [2:0] sck_sy_r;
    logic [2:0] osc_sy_r;
    logic sck_lvl_r, osc_lvl_r;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_sy_r <= 3'h7;
            osc_sy_r <= 3'h0;
        end else begin
            sck_sy_r <= {sck_sy_r[1:0], sck_pin_i};
            osc_sy_r <= {osc_sy_r[1:0], oscillator_select_pin_i};
        end
    end
    // Level accepted once stages two and three agree
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_lvl_r <= 1'b1;
            osc_lvl_r <= 1'b0;
        end else begin
            if (sck_sy_r[2] == sck_sy_r[1]) sck_lvl_r <= sck_sy_r[2];
            if (osc_sy_r[2] == osc_sy_r[1]) osc_lvl_r <= osc_sy_r[2];
        end
    end
    // Select pin about to be accepted high: one rising edge of an outside clock
    wire osc_rise = !osc_lvl_r && osc_sy_r[2] && osc_sy_r[1];
    // Select pin about to change its accepted level either way
    wire osc_move = (osc_sy_r[2] == osc_sy_r[1]) && (osc_sy_r[2] != osc_lvl_r);

    // Cycles since the select pin last moved; a pin still for a whole internal
    // pace period counts as static, so a tied pin never paces from one edge
    logic [$clog2(SAMPLE_DIV+1)-1:0] osc_idle_r;
    wire osc_static = (osc_idle_r == $bits(osc_idle_r)'(SAMPLE_DIV));
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) osc_idle_r <= $bits(osc_idle_r)'(SAMPLE_DIV);
        else if (osc_move) osc_idle_r <= '0;
        else if (!osc_static) osc_idle_r <= osc_idle_r + 1'b1;
    end

    // Power-on counter
    logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_r;
    wire por_end = (por_cnt_r == $bits(por_cnt_r)'(POR_LEN));
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) por_cnt_r <= '0;
        else if (!por_end) por_cnt_r <= por_cnt_r + 1'b1;
    end

    // Mode strap, taken from the pin level as power-on ends
    logic mode_r;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r <= 1'b0;
        // [R2] Strap at end
        end else if (state_r == S_POR && por_end) begin
            // [R3] [R4] High means internal
            mode_r <= sck_lvl_r;
        end
    end

    // Internal oscillator divider; ext clock edges used otherwise
    logic [$clog2(SAMPLE_DIV)-1:0] div_r;
    wire int_tick = (div_r == $bits(div_r)'(SAMPLE_DIV-1));
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) div_r <= '0;
        else div_r <= int_tick ? '0 : div_r + 1'b1;
    end
    // [R11] [R13] Pace select
    wire pace = osc_static ? int_tick : osc_rise;

    // Head of the result fifo, taken when a conversion completes in internal mode
    logic [RESULT_W-1:0] fifo_data;
    logic fifo_valid;

    // Conversion sample counter
    logic [4:0] samp_r;
    wire conv_done = (samp_r == 5'(CONV_SAMPLES)) && fifo_valid;

    // Serial bit timer and edge count
    logic [2:0] half_r;
    logic [4:0] edge_r;
    logic [RESULT_W:0] shreg_r;
    logic sck_r, sdo_r;
    wire half_tick = (half_r == 3'(HALF_BIT_CYCLES-1));

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_POR: if (por_end) state_nxt = S_CONV;
            S_CONV: if (conv_done && mode_r) state_nxt = S_DONE;
            // [R7] First rising edge opens the output
            S_DONE: if (half_tick) state_nxt = S_SHIFT;
            // [R10] [R12] Return to converting
            S_SHIFT: if (half_tick && sck_r && edge_r == LAST_EDGE) state_nxt = S_CONV;
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) state_r <= S_POR;
        else state_r <= state_nxt;
    end

    // Sample counter; conversion waits on fifo data
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) samp_r <= '0;
        else if (state_r != S_CONV) samp_r <= '0;
        else if (pace && samp_r != 5'(CONV_SAMPLES)) samp_r <= samp_r + 1'b1;
    end

    // Half-bit timer runs only in the done and shift states
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) half_r <= '0;
        else if (state_r == S_DONE || state_r == S_SHIFT) half_r <= half_tick ? '0 : half_r + 1'b1;
        else half_r <= '0;
    end

    // Pin drivers and shifter
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_r <= SCK_RST;
            sdo_r <= SDO_RST;
            edge_r <= '0;
            shreg_r <= '0;
        end else begin
            unique case (state_r)
                S_POR: begin
                    sck_r <= SCK_RST;
                    sdo_r <= SDO_RST;
                end
                S_CONV: begin
                    edge_r <= '0;
                    if (conv_done && mode_r) begin
                        // [R6] Both pins low
                        sck_r <= 1'b0;
                        sdo_r <= 1'b0;
                        shreg_r <= {1'b0, fifo_data};
                    end else begin
                        // [R5] Busy shows high
                        sck_r <= 1'b1;
                        sdo_r <= 1'b1;
                    end
                end
                S_DONE: if (half_tick) begin
                    sck_r <= 1'b1;
                    edge_r <= 5'd1;
                end
                S_SHIFT: if (half_tick) begin
                    if (sck_r) begin
                        if (edge_r == LAST_EDGE) begin
                            // [R10] New conversion flag
                            sdo_r <= 1'b1;
                        end else begin
                            // [R8] Falling edge shifts data
                            sck_r <= 1'b0;
                            sdo_r <= shreg_r[RESULT_W-1];
                            shreg_r <= {shreg_r[RESULT_W-1:0], 1'b0};
                        end
                    end else begin
                        sck_r <= 1'b1;
                        edge_r <= edge_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // Pacing tick for the modulator
    logic tick_r;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) tick_r <= 1'b0;
        else tick_r <= pace && state_r == S_CONV;
    end

    // Result fifo: filled by the modulator, drained when a conversion completes in internal mode
    logic fifo_in_ready;
    logic [RESULT_W-1:0] result_q;
    logic rdy_r;
    logic [2:0] occ_r;
    logic [2:0] occ_nxt;
    wire fifo_push = result_valid_i && rdy_r;
    wire fifo_pop = conv_done && mode_r && state_r == S_CONV;
    result_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .in_data_i(result_i),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_in_ready),
        .out_data_o(result_q),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop)
    );
    assign fifo_data = result_q;

    // Fill mirror: lets ready leave a flop, at the cost of three bits
    // that follow the fifo's own count step for step
    assign occ_nxt = occ_r + 3'(fifo_push) - 3'(fifo_pop);
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            occ_r <= '0;
            rdy_r <= 1'b0;
        end else begin
            occ_r <= occ_nxt;
            rdy_r <= (occ_nxt != 3'(FIFO_DEPTH));
        end
    end

    // [R1] Outputs registered; drive only after strap
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_oe_o <= 1'b0;
            sdo_oe_o <= 1'b0;
            int_mode_o <= 1'b0;
        end else begin
            sck_oe_o <= mode_r && state_r != S_POR;
            sdo_oe_o <= state_r != S_POR;
            int_mode_o <= mode_r;
        end
    end
    assign sck_o = sck_r;
    assign sdo_o = sdo_r;
    assign sample_tick_o = tick_r;
    assign result_ready_o = rdy_r;

    // Nineteen rising edges per frame
    // [R7] Edge count bound
    edge_bound_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R7]
        state_r == S_SHIFT |-> edge_r <= LAST_EDGE) else $error("edge count past nineteen");
    // [R5] Busy pins high
    conv_high_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R5]
        $past(state_r) == S_CONV && state_r == S_CONV |-> sck_r && sdo_r) else $error("busy pins not high");
    // [R6] Done pulls low
    done_low_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R6]
        state_r == S_CONV && state_nxt == S_DONE |=> !sck_r && !sdo_r) else $error("done not low");
    // [R10] End flag high
    end_high_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R10]
        state_r == S_SHIFT && state_nxt == S_CONV |=> sdo_r && sck_r) else $error("end flag not high");
    // [R8] Data moves only on fall
    data_fall_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R8]
        state_r == S_SHIFT && $changed(sdo_r) && $past(state_r) == S_SHIFT |-> !sck_r || edge_r == LAST_EDGE)
        else $error("data changed off falling edge");
    // [R2] Strap stable after power-on
    strap_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R2]
        state_r != S_POR && $past(state_r) != S_POR |-> $stable(mode_r)) else $error("mode moved");
    // [R12] Shift ends in new conversion
    repeat_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R12]
        state_r == S_DONE |-> ##[1:200] state_r == S_CONV) else $error("no new conversion");
    // [R4] External mode stays silent
    ext_quiet_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R4]
        !mode_r && state_r != S_POR |-> state_r == S_CONV) else $error("shift in external mode");
    // [R12] Ready never runs ahead of the fifo
    ready_track_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R12]
        rdy_r |-> fifo_in_ready) else $error("ready while fifo full");
endmodule : conv_out
`default_nettype wire

// [common/conv_out_pkg.sv]
package conv_out_pkg;
    // Link and frame shape
    localparam int unsigned BIT_COUNT = 19;
    localparam logic [4:0] LAST_EDGE = 5'd19;
    // Master clock rate
    localparam int unsigned CLK_HZ = 20000000;
    // Power-on settle time before the clock-source strap is taken
    localparam int unsigned POR_US = 1000;
    localparam int unsigned POR_CYCLES = (CLK_HZ / 1000000) * POR_US;
    // Internal sampling network rate
    localparam int unsigned SAMPLE_HZ = 69900;
    localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    // Samples taken per conversion, whether paced internally or by the select pin
    localparam int unsigned CONV_SAMPLES = 16;
    // Half period of the serial clock in master cycles
    localparam int unsigned HALF_BIT_CYCLES = 4;
    // Fifo shape
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned RESULT_W = 18;
    // Reset values of the two pins
    localparam logic SCK_RST = 1'b1;
    localparam logic SDO_RST = 1'b1;
endpackage : conv_out_pkg

// [hdl/result_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 4
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    // Storage words, indexed by pointer
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rd_r];
    // Write side
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end
    // Pointers and fill count
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : result_fifo
`default_nettype wire

// [verification/serial_receiver.sv]
`timescale 1ns/100ps
`default_nettype none
// Far-side controller: listens on the two output lines, may strap the clock pin low
module serial_receiver (
    input wire logic resetn_i,
    input wire logic sck_drive_i,
    input wire logic sck_oe_i,
    input wire logic sdo_drive_i,
    input wire logic sdo_oe_i,
    input wire logic hold_low_i,
    output logic sck_line_o,
    output var logic [18:0] frame_o,
    output var logic [7:0] frames_o
);
    logic [4:0] edge_cnt; // Rising edges seen in this frame
    logic [18:0] shift; // Flag then result, first bit ends at the top
    logic sdo_line; // Data wire level as the receiver sees it
    assign sck_line_o = sck_oe_i ? sck_drive_i : !hold_low_i;
    // Undriven data has no pull, so show a changed value rather than a stale one
    assign sdo_line = sdo_oe_i ? sdo_drive_i : !sdo_drive_i;
    always @(posedge sck_line_o or negedge resetn_i or posedge hold_low_i) begin
        if (!resetn_i || hold_low_i) begin
            edge_cnt = 5'h00;
            if (!resetn_i) begin
                frames_o = 8'h00;
            end
        end else begin
            shift = {shift[17:0], sdo_line};
            edge_cnt = edge_cnt + 5'h01;
            // Nineteen rises make one whole word
            if (edge_cnt == 5'h13) begin
                frame_o = shift;
                frames_o = frames_o + 8'h01;
                edge_cnt = 5'h00;
            end
        end
    end
endmodule : serial_receiver
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import conv_out_pkg::*;
    localparam int unsigned POR_SIM = 40; // Short power-on for simulation
    // Reset starts high so its first drop is a real edge for the far-side model
    logic mclk = 1'b0, resetn = 1'b1, osc_sel = 1'b0, hold_low = 1'b0, in_valid = 1'b0, ext_run = 1'b0;
    logic [RESULT_W-1:0] in_data = 18'h00000;
    logic in_ready, sck, sck_oe, sdo, sdo_oe, int_mode, tick, sck_line;
    logic [18:0] frame;
    logic [7:0] frames;
    int fail_count = 0;
    int n_compared = 0;
    conv_out #(.POR_LEN(POR_SIM)) dut (.mclk_i(mclk), .resetn_i(resetn), .result_i(in_data),
        .result_valid_i(in_valid), .result_ready_o(in_ready), .sck_pin_i(sck_line),
        .oscillator_select_pin_i(osc_sel), .sck_o(sck), .sck_oe_o(sck_oe), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .int_mode_o(int_mode), .sample_tick_o(tick));
    serial_receiver partner (.resetn_i(resetn), .sck_drive_i(sck), .sck_oe_i(sck_oe), .sdo_drive_i(sdo),
        .sdo_oe_i(sdo_oe), .hold_low_i(hold_low), .sck_line_o(sck_line), .frame_o(frame), .frames_o(frames));
    // Master clock, 50 ns
    initial begin
        forever #25 mclk = ~mclk;
    end
    // External pacing clock, 400 ns, offset so it never lands on a master edge
    initial begin
        #17;
        forever #200 if (ext_run) osc_sel = ~osc_sel;
    end
    task check_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    task check_word(input string what, input logic [18:0] exp, input logic [18:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word
    task check_count(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_count
    task test_done;
        $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    // Reset with the strap chosen, then wait out power-on before letting go of the pin
    task apply_reset(input logic strap_low);
        @(posedge mclk);
        #5 resetn = 1'b0;
        hold_low = strap_low;
        repeat (8) @(posedge mclk);
        #5 resetn = 1'b1;
        repeat (POR_SIM + 8) @(posedge mclk);
        #5 hold_low = 1'b0;
    endtask : apply_reset
    // Offer one word and hold it until the fifo takes it
    task push(input logic [RESULT_W-1:0] w);
        int k;
        @(posedge mclk);
        #5 in_data = w;
        in_valid = 1'b1;
        k = 0;
        while (in_ready !== 1'b1 && k < 100) begin
            @(posedge mclk);
            #5 k++;
        end
        @(posedge mclk);
        #5 in_valid = 1'b0;
    endtask : push
    task wait_frame(input int n, input int limit);
        int k;
        k = 0;
        while (int'(frames) < n && k < limit) begin
            @(posedge mclk);
            #5 k++;
        end
    endtask : wait_frame
    // Strap floating: four words fill the fifo, then shift out one per conversion
    task run_internal;
        logic [RESULT_W-1:0] words [4];
        int k;
        words = '{18'h2a5c3, 18'h3ffff, 18'h00000, 18'h15555};
        apply_reset(1'b0);
        check_bit("mode latch", 1'b1, int_mode);
        check_bit("clock while converting", 1'b1, sck);
        check_bit("data while converting", 1'b1, sdo);
        check_bit("clock enable", 1'b1, sck_oe);
        check_bit("data enable", 1'b1, sdo_oe);
        for (int i = 0; i < 4; i++) push(words[i]);
        check_bit("fifo refuses when full", 1'b0, in_ready);
        k = 0;
        while (tick !== 1'b1 && k < 1000) begin
            @(posedge mclk);
            #5 k++;
        end
        k = 0;
        do begin
            @(posedge mclk);
            #5 k++;
        end while (tick !== 1'b1 && k < 1000);
        check_count("pace gap", SAMPLE_DIV, k);
        for (int i = 0; i < 4; i++) begin
            wait_frame(i + 1, 6000);
            check_word("frame", {1'b0, words[i]}, frame);
            repeat (8) @(posedge mclk);
            #5;
            check_bit("data after frame", 1'b1, sdo);
            check_bit("clock after frame", 1'b1, sck);
        end
        check_bit("ready once drained", 1'b1, in_ready);
        check_count("frames after four words", 4, frames);
    endtask : run_internal
    // Strap held low: external mode, nothing is shifted out
    task run_strap_low;
        apply_reset(1'b1);
        check_bit("mode latch", 1'b0, int_mode);
        push(18'h0f0f0);
        repeat (5000) @(posedge mclk);
        #5;
        check_count("frames in external mode", 0, frames);
        check_bit("clock held", 1'b1, sck_line);
        check_bit("clock not driven", 1'b0, sck_oe);
    endtask : run_strap_low
    // Select pin clocked: conversions run far quicker than internal pacing allows
    task run_ext_clock;
        apply_reset(1'b0);
        ext_run = 1'b1;
        push(18'h1e2d4);
        wait_frame(1, 2000);
        check_count("frames with external pacing", 1, frames);
        check_word("frame", {1'b0, 18'h1e2d4}, frame);
        ext_run = 1'b0;
    endtask : run_ext_clock
    initial begin
        run_internal;
        run_strap_low;
        run_ext_clock;
        test_done;
    end
    // Whole run is about 1.2 ms; over twice that means a hang
    initial begin
        #3000000;
        fail_count++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        test_done;
    end
endmodule : testbench
`default_nettype wire
